// [design/adc_port_pkg.sv]
// shared constants for the converter digital port
package adc_port_pkg;
  localparam int CHANNELS = 8; // channel count
  localparam int DATA_W = 10; // bits per sample
  localparam int MSB_POS = 9; // msb sits on the highest data pin
  localparam int PIPE_LAT = 7; // sampling periods from sample to output
  localparam int RECOVER_CYCLES = 7; // invalid periods after leaving sleep
  localparam int REC_W = 3; // width of recovery counter
  localparam logic [9:0] CODE_POS_FS = 10'h3ff; // +fs - 1 lsb
  localparam logic [9:0] CODE_HALF_POS = 10'h300; // +1/2 fs
  localparam logic [9:0] CODE_ZERO = 10'h200; // bipolar zero
  localparam logic [9:0] CODE_HALF_NEG = 10'h100; // -1/2 fs
  localparam logic [9:0] CODE_NEG_FS = 10'h000; // -fs
  localparam int CLK_MHZ = 100; // core clock rate
  localparam int MIN_RATE_MSPS = 5; // least sampling rate
  // longest core cycles between sampling edges at the least rate (round down)
  localparam int MAX_GAP_CYCLES = CLK_MHZ / MIN_RATE_MSPS;
  localparam int GAP_W = 5; // width of the gap counter
  localparam int DUTY_LO_TIGHT = 48; // bypass window, percent
  localparam int DUTY_HI_TIGHT = 52;
  localparam int DUTY_LO_WIDE = 30; // conditioned window, percent
  localparam int DUTY_HI_WIDE = 70;
  localparam int DUTY_W = 7; // percent value width
endpackage

// [design/sample_clock_monitor.sv]
// measures the sampled clock: edges, duty cycle and rate
`timescale 1ns/1ns
`default_nettype none
module sample_clock_monitor #(
  parameter int CNT_W = 8
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sclk_sync, // already synchronised sampling clock
  input wire logic duty_adjust_select, // synchronised select level
  output logic rise_pulse, // one-cycle pulse per rising edge
  output logic fall_pulse, // one-cycle pulse per falling edge
  output logic duty_ok, // duty within allowed window for the mode
  output logic rate_ok // sampling rate at or above the floor
);
  initial begin
    if (CNT_W < 6) $error("count width too small for the rate floor");
  end

  logic prev_r, prev_nxt; // last clock level
  logic [CNT_W-1:0] hi_r, hi_nxt; // high time in core cycles
  logic [CNT_W-1:0] per_r, per_nxt; // running period count
  logic [CNT_W-1:0] hi_last_r, hi_last_nxt; // high time of last period
  logic duty_ok_r, duty_ok_nxt;
  logic rate_ok_r, rate_ok_nxt;
  logic [CNT_W+6:0] hi_pct; // scaled high time
  logic [CNT_W+6:0] per_pct; // period in core cycles (per_r + 1), unscaled
  logic rise, fall;

  // edge detect, counting and duty/rate judgement
  always_comb begin
    rise = sclk_sync & ~prev_r;
    fall = ~sclk_sync & prev_r;
    prev_nxt = sclk_sync;
    hi_nxt = hi_r;
    per_nxt = per_r;
    hi_last_nxt = hi_last_r;
    duty_ok_nxt = duty_ok_r;
    rate_ok_nxt = rate_ok_r;
    hi_pct = (CNT_W+7)'(hi_last_r) * (CNT_W+7)'(100);
    per_pct = (CNT_W+7)'(per_r) + (CNT_W+7)'(1);
    if (per_r != {CNT_W{1'b1}}) begin
      per_nxt = per_r + 1'b1; // saturate so a stopped clock is seen
    end
    if (sclk_sync && hi_r != {CNT_W{1'b1}}) begin
      hi_nxt = hi_r + 1'b1;
    end
    if (fall) begin
      hi_last_nxt = hi_r;
    end
    if (rise) begin
      // duty tolerance follows the conditioning mode
      if (duty_adjust_select) begin
        duty_ok_nxt = hi_pct >= per_pct * (CNT_W+7)'(adc_port_pkg::DUTY_LO_WIDE) &&
                      hi_pct <= per_pct * (CNT_W+7)'(adc_port_pkg::DUTY_HI_WIDE);
      end else begin
        duty_ok_nxt = hi_pct >= per_pct * (CNT_W+7)'(adc_port_pkg::DUTY_LO_TIGHT) &&
                      hi_pct <= per_pct * (CNT_W+7)'(adc_port_pkg::DUTY_HI_TIGHT);
      end
      rate_ok_nxt = 1'b1;
      per_nxt = '0;
      // the rise cycle is already high, so it counts as the first high cycle
      hi_nxt = CNT_W'(1);
    end
    if (per_r >= CNT_W'(adc_port_pkg::MAX_GAP_CYCLES)) begin
      rate_ok_nxt = 1'b0;
    end
  end

  // state registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_r <= 1'b0;
      hi_r <= '0;
      per_r <= '0;
      hi_last_r <= '0;
      duty_ok_r <= 1'b0;
      rate_ok_r <= 1'b0;
    end else begin
      prev_r <= prev_nxt;
      hi_r <= hi_nxt;
      per_r <= per_nxt;
      hi_last_r <= hi_last_nxt;
      duty_ok_r <= duty_ok_nxt;
      rate_ok_r <= rate_ok_nxt;
    end
  end

  assign rise_pulse = rise;
  assign fall_pulse = fall;
  assign duty_ok = duty_ok_r;
  assign rate_ok = rate_ok_r;
endmodule
`default_nettype wire

// [design/channel_pipeline.sv]
// one channel's conversion pipeline with sleep invalidation and recovery
`timescale 1ns/1ns
`default_nettype none
module channel_pipeline #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 7,
  parameter int RECOVER = 7
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sample_en, // one pulse per sampling period
  input wire logic awake, // synchronised sleep pin, high = run
  input wire logic [WIDTH-1:0] sample_in, // quantised input code
  output logic [WIDTH-1:0] data_out, // head of the pipeline
  output logic data_valid // output word may be trusted
);
  initial begin
    if (DEPTH < 1 || RECOVER < 1 || RECOVER > 15) $error("bad pipeline parameters");
  end

  logic [WIDTH-1:0] stage_r [DEPTH]; // pipeline storage
  logic [WIDTH-1:0] stage_nxt [DEPTH];
  logic [3:0] rec_r, rec_nxt; // periods still to wait after wake
  logic valid_r, valid_nxt;

  // shift on each sample, flush on sleep
  always_comb begin
    for (int i = 0; i < DEPTH; i++) begin
      stage_nxt[i] = stage_r[i];
    end
    rec_nxt = rec_r;
    valid_nxt = valid_r;
    if (!awake) begin
      // contents are lost whether or not the clock runs
      for (int i = 0; i < DEPTH; i++) begin
        stage_nxt[i] = '0;
      end
      rec_nxt = 4'(RECOVER);
      valid_nxt = 1'b0;
    end else if (sample_en) begin
      stage_nxt[0] = sample_in;
      for (int i = 1; i < DEPTH; i++) begin
        stage_nxt[i] = stage_r[i-1];
      end
      if (rec_r != 4'h0) begin
        rec_nxt = rec_r - 4'h1;
      end
      valid_nxt = (rec_r <= 4'h1);
    end
  end

  // storage registers
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < DEPTH; i++) begin
        stage_r[i] <= '0;
      end
      rec_r <= 4'(RECOVER);
      valid_r <= 1'b0;
    end else begin
      for (int i = 0; i < DEPTH; i++) begin
        stage_r[i] <= stage_nxt[i];
      end
      rec_r <= rec_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign data_out = stage_r[DEPTH-1];
  assign data_valid = valid_r;

  wake_wait_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(awake) |=> !data_valid) else $error("valid survived sleep");
  sleep_flush_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !awake |=> data_out == '0) else $error("pipeline not flushed");
endmodule
`default_nettype wire

// [design/adc_digital_port_control.sv]
// digital port of the eight-channel converter: clocking, coding, enables, sleep
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// - both sampling clock edges used, ideal 50%
// - select low bypasses conditioning, 48-52% duty
// - select high conditions clock, 30-70% duty
// - straight offset binary, msb on pin nine
// - fixed code points from full scale down
// - one low enable drives all eight buses
// - enable high tri-states every channel
// - per channel low sleep input powers down
// - sleep invalidates whole channel pipeline
// - seven clocks of invalid data after wake
module adc_digital_port_control #(
  parameter int NCH = adc_port_pkg::CHANNELS,
  parameter int DW = adc_port_pkg::DATA_W,
  parameter int LAT = adc_port_pkg::PIPE_LAT
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic sample_clk_pin, // sampling clock arriving on a pin
  input wire logic duty_adjust_select, // high = clock conditioning active
  input wire logic output_enable_n, // shared, active low
  input wire logic [NCH-1:0] channel_sleep_n, // per channel, low = power down
  input wire logic [NCH*DW-1:0] quantised_in, // raw codes from the analog core
  output logic [NCH*DW-1:0] data_o, // data bus drive values
  output logic [NCH*DW-1:0] data_oe, // data bus enables, high = driving
  output logic [NCH-1:0] data_valid, // per channel word trustworthy
  output logic clock_duty_ok, // duty within window of the selected mode
  output logic clock_rate_ok, // sampling rate at or above the floor
  output logic sample_strobe // one pulse per captured sample
);
  initial begin
    if (DW != adc_port_pkg::DATA_W || NCH < 1 || LAT < 1) $error("unsupported size");
  end

  // two-stage synchronisers for every pin input
  logic sclk_s1_r, sclk_s2_r;
  logic dsel_s1_r, dsel_s2_r;
  logic oe_s1_r, oe_s2_r;
  logic [NCH-1:0] slp_s1_r, slp_s2_r;

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_s1_r <= 1'b0;
      sclk_s2_r <= 1'b0;
      dsel_s1_r <= 1'b0;
      dsel_s2_r <= 1'b0;
      oe_s1_r <= 1'b1; // outputs start released
      oe_s2_r <= 1'b1;
      slp_s1_r <= '0; // channels start asleep
      slp_s2_r <= '0;
    end else begin
      sclk_s1_r <= sample_clk_pin;
      sclk_s2_r <= sclk_s1_r;
      dsel_s1_r <= duty_adjust_select;
      dsel_s2_r <= dsel_s1_r;
      oe_s1_r <= output_enable_n;
      oe_s2_r <= oe_s1_r;
      slp_s1_r <= channel_sleep_n;
      slp_s2_r <= slp_s1_r;
    end
  end

  logic rise_p, fall_p, duty_ok_w, rate_ok_w;

  // clock watch: both edges seen, duty checked per mode
  sample_clock_monitor #(.CNT_W(8)) u_mon (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .sclk_sync(sclk_s2_r),
    .duty_adjust_select(dsel_s2_r),
    .rise_pulse(rise_p),
    .fall_pulse(fall_p),
    .duty_ok(duty_ok_w),
    .rate_ok(rate_ok_w)
  );

  // rising edge arms the phase; the falling edge after it advances the pipeline and latches the code
  logic phase_r, phase_nxt; // high between rise and fall
  logic adv_r, adv_nxt; // pipeline advance pulse
  always_comb begin
    phase_nxt = phase_r;
    adv_nxt = 1'b0;
    if (rise_p) begin
      phase_nxt = 1'b1;
    end
    if (fall_p && phase_r) begin
      phase_nxt = 1'b0;
      adv_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_r <= 1'b0;
      adv_r <= 1'b0;
    end else begin
      phase_r <= phase_nxt;
      adv_r <= adv_nxt;
    end
  end

  logic [NCH*DW-1:0] pipe_data;
  logic [NCH-1:0] pipe_valid;

  // one pipeline per channel, all advanced by the same pulse
  genvar ch;
  generate
    for (ch = 0; ch < NCH; ch++) begin : g_ch
      channel_pipeline #(
        .WIDTH(DW),
        .DEPTH(LAT),
        .RECOVER(adc_port_pkg::RECOVER_CYCLES)
      ) u_pipe (
        .core_clk(core_clk),
        .rst_n(rst_n),
        .sample_en(adv_r),
        .awake(slp_s2_r[ch]),
        .sample_in(quantised_in[ch*DW +: DW]),
        .data_out(pipe_data[ch*DW +: DW]),
        .data_valid(pipe_valid[ch])
      );
    end
  endgenerate

  // output stage: codes pass straight through, bit 9 is msb
  logic [NCH*DW-1:0] dout_r, dout_nxt;
  logic [NCH*DW-1:0] doe_r, doe_nxt;
  logic [NCH-1:0] dval_r, dval_nxt;
  logic duty_r, rate_r, strobe_r, strobe_nxt;

  always_comb begin
    dout_nxt = pipe_data;
    // a single shared enable gates all buses together
    doe_nxt = oe_s2_r ? '0 : '1;
    dval_nxt = pipe_valid & slp_s2_r;
    strobe_nxt = adv_r;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dout_r <= '0;
      doe_r <= '0;
      dval_r <= '0;
      duty_r <= 1'b0;
      rate_r <= 1'b0;
      strobe_r <= 1'b0;
    end else begin
      dout_r <= dout_nxt;
      doe_r <= doe_nxt;
      dval_r <= dval_nxt;
      duty_r <= duty_ok_w;
      rate_r <= rate_ok_w;
      strobe_r <= strobe_nxt;
    end
  end

  assign data_o = dout_r;
  assign data_oe = doe_r;
  assign data_valid = dval_r;
  assign clock_duty_ok = duty_r;
  assign clock_rate_ok = rate_r;
  assign sample_strobe = strobe_r;

  // checks
  oe_release_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    oe_s2_r |=> data_oe == '0) else $error("bus driven while disabled");
  oe_drive_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !oe_s2_r |=> data_oe == '1) else $error("bus not driven while enabled");
  sleep_invalid_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !slp_s2_r[0] |=> !data_valid[0]) else $error("sleeping channel valid");
  code_pass_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    1'b1 |=> data_o == $past(pipe_data)) else $error("code altered");
  zero_code_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    pipe_data[DW-1:0] == adc_port_pkg::CODE_ZERO |=>
    data_o[adc_port_pkg::MSB_POS] == 1'b1) else $error("msb misplaced");
  advance_fall_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    adv_r |-> $past(fall_p, 1)) else $error("advance not on fall");
  strobe_follow_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    adv_r |=> sample_strobe) else $error("strobe missing");
  rate_floor_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !sclk_s2_r [*8] ##1 !sclk_s2_r [*8] ##1 !sclk_s2_r [*8] |-> ##2 !clock_rate_ok)
    else $error("slow clock not flagged");
  // new words are announced by a single-cycle pulse, never a level
  strobe_single_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    sample_strobe |=> !sample_strobe) else $error("strobe longer than one cycle");
  // the shared enable moves all bus bits together, never a part of them
  oe_uniform_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    data_oe == '0 || data_oe == '1) else $error("bus enables split");
  // with every channel awake, words move only on an advance
  data_steady_a: assert property (@(posedge core_clk) disable iff (!rst_n)
    !adv_r && (&slp_s2_r) |-> ##2 $stable(data_o)) else $error("word moved between samples");

  // per channel watch of sleep flushing and the wake recovery window
  genvar chk;
  generate
    for (chk = 0; chk < NCH; chk++) begin : g_chk
      logic [3:0] wake_adv_r, wake_adv_nxt; // advances seen since wake, saturating

      // counts the same advances the channel's recovery counter sees
      always_comb begin
        wake_adv_nxt = wake_adv_r;
        if (!slp_s2_r[chk]) begin
          wake_adv_nxt = '0; // asleep: window starts again
        end else if (adv_r && wake_adv_r != 4'hf) begin
          wake_adv_nxt = wake_adv_r + 4'h1;
        end
      end

      // helper register only
      always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          wake_adv_r <= '0;
        end else begin
          wake_adv_r <= wake_adv_nxt;
        end
      end

      // a sleeping channel never reports a valid word
      sleep_quiet_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !slp_s2_r[chk] |=> !data_valid[chk]) else $error("sleeping channel valid");
      // the flushed pipeline reaches the bus two edges after sleep is seen
      sleep_zero_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        !slp_s2_r[chk] ##1 !slp_s2_r[chk] |=> data_o[chk*DW +: DW] == '0)
        else $error("sleeping channel not flushed");
      // inside the recovery window the word stays marked invalid
      wake_hold_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        wake_adv_r < 4'(adc_port_pkg::RECOVER_CYCLES) |=> !data_valid[chk])
        else $error("valid inside recovery window");
      // once the window is over an awake channel is trusted again
      wake_valid_a: assert property (@(posedge core_clk) disable iff (!rst_n)
        slp_s2_r[chk] && wake_adv_r >= 4'(adc_port_pkg::RECOVER_CYCLES) |=> data_valid[chk])
        else $error("valid missing after recovery");
    end
  endgenerate
endmodule
`default_nettype wire

// [tb/capture_partner.sv]
// downstream capture model: sampling clock source and word latch
`timescale 1ns/1ns
`default_nettype none
module capture_partner (
  input wire logic core_clk,
  input wire logic [7:0] hi_cyc, // high time of sampling clock, core cycles
  input wire logic [7:0] lo_cyc, // low time of sampling clock, core cycles
  input wire logic [7:0] data_valid, // per channel trust flags
  input wire logic sample_strobe, // new words announced
  output logic sample_clk_pin, // sampling clock towards the converter
  output var int words_taken // words latched so far
);
  int ph_cnt; // cycles spent in the present clock phase
  initial begin
    sample_clk_pin = 1'b0;
    ph_cnt = 0;
    words_taken = 0;
  end
  // free running square wave; rate and duty set by the bench
  always @(posedge core_clk) begin
    if (ph_cnt + 1 >= int'(sample_clk_pin ? hi_cyc : lo_cyc)) begin
      sample_clk_pin <= ~sample_clk_pin;
      ph_cnt <= 0;
    end else begin
      ph_cnt <= ph_cnt + 1;
    end
  end
  // sleeping or recovering channels are ignored, not latched
  always @(posedge core_clk) begin
    if (sample_strobe === 1'b1) begin
      words_taken <= words_taken + $countones(data_valid);
    end
  end
endmodule
`default_nettype wire

// [tb/adc_digital_port_control_tb_top.sv]
// self-checking bench for the converter digital port
`timescale 1ns/1ns
`default_nettype none
module adc_digital_port_control_tb_top;
  localparam int DW = adc_port_pkg::DATA_W;
  localparam int NB = adc_port_pkg::CHANNELS * DW;
  logic core_clk, rst_n, duty_adjust_select, output_enable_n;
  logic sample_clk_pin, clock_duty_ok, clock_rate_ok, sample_strobe;
  logic [7:0] channel_sleep_n, data_valid, hi_cyc, lo_cyc;
  logic [NB-1:0] quantised_in, data_o, data_oe, v, a_q;
  logic [DW-1:0] codes [5]; // the documented code points
  int words_taken, err_count, compares, cyc, k;
  int seed = 83597; // fixed so runs repeat
  adc_digital_port_control dut_u (.core_clk(core_clk), .rst_n(rst_n),
    .sample_clk_pin(sample_clk_pin), .duty_adjust_select(duty_adjust_select),
    .output_enable_n(output_enable_n), .channel_sleep_n(channel_sleep_n),
    .quantised_in(quantised_in), .data_o(data_o), .data_oe(data_oe),
    .data_valid(data_valid), .clock_duty_ok(clock_duty_ok),
    .clock_rate_ok(clock_rate_ok), .sample_strobe(sample_strobe));
  capture_partner partner_u (.core_clk(core_clk), .hi_cyc(hi_cyc), .lo_cyc(lo_cyc),
    .data_valid(data_valid), .sample_strobe(sample_strobe),
    .sample_clk_pin(sample_clk_pin), .words_taken(words_taken));
  task automatic chk_bus(input logic [NB-1:0] got, input logic [NB-1:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("errors=%0d compares=%0d", err_count, compares);
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // sleeping channels hold a zeroed pipeline
  function automatic logic [NB-1:0] exp_bus(input logic [NB-1:0] q, input logic [7:0] awake);
    logic [NB-1:0] r;
    r = q;
    for (int c = 0; c < 8; c++) if (!awake[c]) r[c*DW +: DW] = '0;
    return r;
  endfunction
  // window depends on the select level; coarse, so margins are kept wide
  function automatic logic exp_duty(input logic sel, input int hi, input int lo);
    int pct;
    pct = hi * 100 / (hi + lo);
    if (sel) return pct >= adc_port_pkg::DUTY_LO_WIDE && pct <= adc_port_pkg::DUTY_HI_WIDE;
    return pct >= adc_port_pkg::DUTY_LO_TIGHT && pct <= adc_port_pkg::DUTY_HI_TIGHT;
  endfunction
  // counts strobes, sampling just after each edge has landed
  task automatic wait_strobes(input int n);
    int got;
    got = 0;
    while (got < n) begin
      @(posedge core_clk);
      #1;
      if (sample_strobe === 1'b1) got++;
    end
  endtask
  task automatic drive_q(input logic [NB-1:0] q);
    @(posedge core_clk);
    quantised_in <= q;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  // cuts a hang short
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_count++;
      report_and_stop();
    end
  end
  initial begin
    codes = '{adc_port_pkg::CODE_POS_FS, adc_port_pkg::CODE_HALF_POS,
      adc_port_pkg::CODE_ZERO, adc_port_pkg::CODE_HALF_NEG, adc_port_pkg::CODE_NEG_FS};
    rst_n = 1'b0;
    output_enable_n = 1'b1; // defined level from time zero
    duty_adjust_select = 1'b1;
    channel_sleep_n = 8'hff;
    quantised_in = '0;
    hi_cyc = 8'h05;
    lo_cyc = 8'h05;
    repeat (3) @(posedge core_clk);
    chk_bus(data_oe, '0);
    rst_n <= 1'b1;
    // shared enable drives every bus together; release is checked at the end
    @(posedge core_clk);
    output_enable_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    chk_bus(data_oe, '1);
    // code points rotated over the channels, then random codes
    for (int i = 0; i < 9; i++) begin
      for (int c = 0; c < 8; c++) begin
        v[c*DW +: DW] = (i < 5) ? codes[(i + c) % 5] : DW'($random(seed));
      end
      drive_q(v);
      wait_strobes(9);
      chk_bus(data_o, exp_bus(v, 8'hff));
    end
    // a change reaches the bus only after the fixed latency
    a_q = v;
    v = ~v;
    drive_q(v);
    wait_strobes(5);
    chk_bus(data_o, a_q);
    wait_strobes(4);
    chk_bus(data_o, v);
    // sleep one random channel, then wake it
    k = {$random(seed)} % 8;
    @(posedge core_clk);
    channel_sleep_n[k] <= 1'b0; // held through a full window, no multiplexing
    wait_strobes(9);
    chk_bus(data_o, exp_bus(v, ~(8'h01 << k)));
    chk_bus({72'h0, data_valid}, {72'h0, ~(8'h01 << k)});
    @(posedge core_clk);
    channel_sleep_n[k] <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      wait_strobes(1);
      chk_bit(data_valid[k], 1'b0);
    end
    wait_strobes(3);
    // valid is registered one edge after the strobe of the last recovery advance
    @(posedge core_clk);
    #1;
    chk_bit(data_valid[k], 1'b1);
    chk_bus(data_o, v);
    // duty windows for both select levels, and the rate floor
    for (int i = 0; i < 5; i++) begin
      @(posedge core_clk);
      duty_adjust_select <= (i != 1 && i != 2);
      hi_cyc <= 8'(i == 4 ? 15 : (i == 2 ? 5 : (i == 3 ? 3 : 4)));
      lo_cyc <= 8'(i == 4 ? 15 : (i == 2 ? 5 : (i == 3 ? 9 : 6)));
      repeat (120) @(posedge core_clk);
      #1;
      chk_bit(clock_duty_ok, exp_duty(duty_adjust_select, hi_cyc, lo_cyc));
      chk_bit(clock_rate_ok, (hi_cyc + lo_cyc) < adc_port_pkg::MAX_GAP_CYCLES);
    end
    @(posedge core_clk);
    output_enable_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    chk_bus(data_oe, '0);
    chk_bit(words_taken > 0, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire
